// ==== rtl/dioc_defines.vh ====
// constants for the drive io conditioning block
`ifndef DIOC_DEFINES_VH
`define DIOC_DEFINES_VH
// register byte offsets
`define DIOC_OFF_AOUT1_CFG 8'h00
`define DIOC_OFF_AOUT2_CFG 8'h04
`define DIOC_OFF_HOST_SRC_A 8'h08
`define DIOC_OFF_HOST_SRC_B 8'h0c
`define DIOC_OFF_PULSE_SEL 8'h10
`define DIOC_OFF_PULSE_GAIN 8'h14
`define DIOC_OFF_BAND_LOW 8'h18
`define DIOC_OFF_BAND_HIGH 8'h1c
`define DIOC_OFF_PULSE_OFFSET 8'h20
`define DIOC_OFF_FILTER_TIME 8'h24
`define DIOC_OFF_POLARITY 8'h28
`define DIOC_OFF_FUNC_LO 8'h2c
`define DIOC_OFF_FUNC_HI 8'h30
`define DIOC_OFF_DI_STATE 8'h34
`define DIOC_OFF_PULSE_HZ 8'h38
`define DIOC_OFF_PULSE_VALUE 8'h3c
`define DIOC_OFF_AOUT_LEVELS 8'h40
// analog output config field positions
`define DIOC_AO_GAIN_MSB 13
`define DIOC_AO_TYPE_LSB 16
`define DIOC_AO_SRC_LSB 20
// reset values and limits
`define DIOC_GAIN_UNITY 14'h03e8
`define DIOC_GAIN_MAX 14'h270f
`define DIOC_TYPE_DEFAULT 3'h0
`define DIOC_TYPE_MAX 3'h5
`define DIOC_BAND_LOW_DEFAULT 12'h064
`define DIOC_BAND_HIGH_DEFAULT 12'h3e8
`define DIOC_HZ_MAX 12'hbb8
`define DIOC_OFFSET_LIMIT 1000
`define DIOC_FILTER_MAX 11'h640
`define DIOC_FUNC_MAX 6'h39
`define DIOC_FUNC_FIRE 6'h31
`define DIOC_PULSE_SEL_MAX 3'h4
// output spans in mV or uA
`define DIOC_SPAN_VOLT 16'h2710
`define DIOC_SPAN_CUR 16'h4e20
`define DIOC_SPAN_LIVE 16'h3e80
`define DIOC_LIVE_ZERO 16'h0fa0
// normalising full scales
`define DIOC_SCALE_WORD 32767
`define DIOC_SCALE_TORQUE 2000
`define DIOC_PCT_FULL 1000
// timing
`define DIOC_CLK_KHZ 125000
`define DIOC_GATE_TIME_MS 1000
`define DIOC_FILTER_STEP_MS 10
`define DIOC_GATE_CYCLES (`DIOC_GATE_TIME_MS * `DIOC_CLK_KHZ)
`define DIOC_STEP_CYCLES (`DIOC_FILTER_STEP_MS * `DIOC_CLK_KHZ)
`endif

// ==== rtl/dioc_top.v ====
// drive io conditioning: analog outputs, pulse rate input, input status word
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`include "dioc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module dioc_top #(
    parameter GATE_CYCLES = `DIOC_GATE_CYCLES,
    parameter STEP_CYCLES = `DIOC_STEP_CYCLES
) (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // drive side
    input wire driveStopped,
    input wire [15:0] scriptValue,
    input wire [15:0] torqueValue,
    output reg [15:0] pulseValue_ff,
    output reg fireModeReq_ff,
    // field side
    input wire [7:0] digitalInputPin,
    output reg [15:0] aout1Level_ff,
    output reg [15:0] aout2Level_ff
);

    // ----------------------------------------
    // configuration and status state
    // ----------------------------------------
    reg [21:0] aout1Cfg_ff;
    reg [21:0] aout2Cfg_ff;
    reg [15:0] hostSrcA_ff;
    reg [15:0] hostSrcB_ff;
    reg [2:0] pulseSel_ff;
    reg [13:0] pulseGain_ff;
    reg [11:0] bandLow_ff;
    reg [11:0] bandHigh_ff;
    reg [10:0] pulseOffset_ff;
    reg [10:0] filterTime_ff;
    reg polarity_ff;
    reg [47:0] inputFunc_ff;
    reg [7:0] diState_ff;
    reg [11:0] pulseHz_ff;

    // ----------------------------------------
    // arithmetic
    // ----------------------------------------
    // level in mV (voltage types) or uA (current types)
    function [15:0] aoLevel;
        input [21:0] cfg;
        input [15:0] hostA;
        input [15:0] hostB;
        input [15:0] script;
        input [15:0] torque;
        reg [15:0] val;
        reg [15:0] span;
        reg [47:0] scaled;
        reg [31:0] scale;
        begin
            case (cfg[`DIOC_AO_SRC_LSB +: 2])
                2'h0: val = hostA;
                2'h1: val = hostB;
                2'h2: val = script;
                default: val = torque;
            endcase
            scale = (cfg[`DIOC_AO_SRC_LSB +: 2] == 2'h3) ? `DIOC_SCALE_TORQUE : `DIOC_SCALE_WORD;
            case (cfg[`DIOC_AO_TYPE_LSB +: 3])
                3'h0, 3'h3: span = `DIOC_SPAN_VOLT;
                3'h2, 3'h5: span = `DIOC_SPAN_LIVE;
                default: span = `DIOC_SPAN_CUR;
            endcase
            scaled = ({32'h0, val} * {34'h0, cfg[`DIOC_AO_GAIN_MSB:0]} * {32'h0, span})
                / ({16'h0, scale} * `DIOC_PCT_FULL);
            if (scaled > {32'h0, span})
                scaled = {32'h0, span};
            case (cfg[`DIOC_AO_TYPE_LSB +: 3])
                3'h0, 3'h1: aoLevel = scaled[15:0];
                3'h2: aoLevel = `DIOC_LIVE_ZERO + scaled[15:0];
                3'h3: aoLevel = `DIOC_SPAN_VOLT - scaled[15:0];
                default: aoLevel = `DIOC_SPAN_CUR - scaled[15:0];
            endcase
        end
    endfunction

    // signed result, +-32767 stands for +-100 %
    function [15:0] pulsePercent;
        input [11:0] hz;
        input [11:0] low;
        input [11:0] high;
        input [10:0] offs;
        input [13:0] gain;
        integer band;
        integer frac;
        integer sum;
        integer lowI;
        reg signed [47:0] prod;
        begin
            // signed throughout so a rate below the band gives a negative term
            lowI = {20'h0, low};
            band = {20'h0, high} - lowI;
            if (band <= 0)
                frac = 0;
            else
                frac = (($signed({20'h0, hz}) - lowI) * `DIOC_SCALE_WORD) / band;
            sum = frac + ($signed(offs) * `DIOC_SCALE_WORD) / `DIOC_PCT_FULL;
            // wide product: a narrow band times full gain overflows 32 bits
            prod = sum * $signed({18'h0, gain});
            prod = prod / `DIOC_PCT_FULL;
            if (prod > `DIOC_SCALE_WORD)
                prod = `DIOC_SCALE_WORD;
            if (prod < -`DIOC_SCALE_WORD)
                prod = -`DIOC_SCALE_WORD;
            pulsePercent = prod[15:0];
        end
    endfunction

    function funcOk;
        input [23:0] codes;
        begin
            funcOk = (codes[5:0] <= `DIOC_FUNC_MAX) && (codes[11:6] <= `DIOC_FUNC_MAX)
                && (codes[17:12] <= `DIOC_FUNC_MAX) && (codes[23:18] <= `DIOC_FUNC_MAX);
        end
    endfunction

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    reg awHeld_ff;
    reg wHeld_ff;
    reg [7:0] awAddr_ff;
    reg [31:0] wData_ff;
    wire doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    reg wrHit;
    reg [31:0] rdVal;
    reg rdHit;
    wire signed [15:0] offsIn = wData_ff[15:0];

    always @*
    begin
        case (awAddr_ff)
            `DIOC_OFF_AOUT1_CFG, `DIOC_OFF_AOUT2_CFG, `DIOC_OFF_HOST_SRC_A,
            `DIOC_OFF_HOST_SRC_B, `DIOC_OFF_PULSE_SEL, `DIOC_OFF_PULSE_GAIN,
            `DIOC_OFF_BAND_LOW, `DIOC_OFF_BAND_HIGH, `DIOC_OFF_PULSE_OFFSET,
            `DIOC_OFF_FILTER_TIME, `DIOC_OFF_POLARITY, `DIOC_OFF_FUNC_LO,
            `DIOC_OFF_FUNC_HI: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    always @*
    begin
        rdHit = 1'b1;
        rdVal = 32'h0;
        case (s_axi_araddr)
            `DIOC_OFF_AOUT1_CFG: rdVal = {10'h0, aout1Cfg_ff};
            `DIOC_OFF_AOUT2_CFG: rdVal = {10'h0, aout2Cfg_ff};
            `DIOC_OFF_HOST_SRC_A: rdVal = {16'h0, hostSrcA_ff};
            `DIOC_OFF_HOST_SRC_B: rdVal = {16'h0, hostSrcB_ff};
            `DIOC_OFF_PULSE_SEL: rdVal = {29'h0, pulseSel_ff};
            `DIOC_OFF_PULSE_GAIN: rdVal = {18'h0, pulseGain_ff};
            `DIOC_OFF_BAND_LOW: rdVal = {20'h0, bandLow_ff};
            `DIOC_OFF_BAND_HIGH: rdVal = {20'h0, bandHigh_ff};
            `DIOC_OFF_PULSE_OFFSET: rdVal = {{21{pulseOffset_ff[10]}}, pulseOffset_ff};
            `DIOC_OFF_FILTER_TIME: rdVal = {21'h0, filterTime_ff};
            `DIOC_OFF_POLARITY: rdVal = {31'h0, polarity_ff};
            `DIOC_OFF_FUNC_LO: rdVal = {2'h0, inputFunc_ff[23:18], 2'h0, inputFunc_ff[17:12],
                2'h0, inputFunc_ff[11:6], 2'h0, inputFunc_ff[5:0]};
            `DIOC_OFF_FUNC_HI: rdVal = {2'h0, inputFunc_ff[47:42], 2'h0, inputFunc_ff[41:36],
                2'h0, inputFunc_ff[35:30], 2'h0, inputFunc_ff[29:24]};
            `DIOC_OFF_DI_STATE: rdVal = {24'h0, diState_ff};
            `DIOC_OFF_PULSE_HZ: rdVal = {20'h0, pulseHz_ff};
            `DIOC_OFF_PULSE_VALUE: rdVal = {16'h0, pulseValue_ff};
            `DIOC_OFF_AOUT_LEVELS: rdVal = {aout2Level_ff, aout1Level_ff};
            default: rdHit = 1'b0;
        endcase
    end

    // byte lanes are not split: a word write needs all four strobes set
    wire fullWord = &s_axi_wstrb;
    reg wFull_ff;
    wire [23:0] funcIn = {wData_ff[29:24], wData_ff[21:16], wData_ff[13:8], wData_ff[5:0]};

    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            wFull_ff <= 1'b0;
            awAddr_ff <= 8'h0;
            wData_ff <= 32'h0;
            aout1Cfg_ff <= {2'h0, 1'b0, `DIOC_TYPE_DEFAULT, 2'h0, `DIOC_GAIN_UNITY};
            aout2Cfg_ff <= {2'h0, 1'b0, `DIOC_TYPE_DEFAULT, 2'h0, `DIOC_GAIN_UNITY};
            hostSrcA_ff <= 16'h0;
            hostSrcB_ff <= 16'h0;
            pulseSel_ff <= 3'h0;
            pulseGain_ff <= `DIOC_GAIN_UNITY;
            bandLow_ff <= `DIOC_BAND_LOW_DEFAULT;
            bandHigh_ff <= `DIOC_BAND_HIGH_DEFAULT;
            pulseOffset_ff <= 11'h0;
            filterTime_ff <= 11'h0;
            polarity_ff <= 1'b0;
            inputFunc_ff <= 48'h0;
        end
        else
        begin
            s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wFull_ff <= fullWord;
            end
            if (doWrite)
            begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // out-of-range values are dropped, the old setting stays
            if (doWrite && wFull_ff)
            begin
                case (awAddr_ff)
                    `DIOC_OFF_AOUT1_CFG:
                        if (wData_ff[13:0] <= `DIOC_GAIN_MAX && wData_ff[18:16] <= `DIOC_TYPE_MAX)
                            aout1Cfg_ff <= {wData_ff[21:20], 1'b0, wData_ff[18:16], 2'h0,
                                wData_ff[13:0]};
                    `DIOC_OFF_AOUT2_CFG:
                        if (wData_ff[13:0] <= `DIOC_GAIN_MAX && wData_ff[18:16] <= `DIOC_TYPE_MAX)
                            aout2Cfg_ff <= {wData_ff[21:20], 1'b0, wData_ff[18:16], 2'h0,
                                wData_ff[13:0]};
                    `DIOC_OFF_HOST_SRC_A: hostSrcA_ff <= wData_ff[15:0];
                    `DIOC_OFF_HOST_SRC_B: hostSrcB_ff <= wData_ff[15:0];
                    `DIOC_OFF_PULSE_SEL:
                        if (driveStopped && wData_ff[2:0] <= `DIOC_PULSE_SEL_MAX)
                            pulseSel_ff <= wData_ff[2:0];
                    `DIOC_OFF_PULSE_GAIN:
                        if (wData_ff[13:0] <= `DIOC_GAIN_MAX)
                            pulseGain_ff <= wData_ff[13:0];
                    `DIOC_OFF_BAND_LOW:
                        if (wData_ff[11:0] != 12'h0 && wData_ff[11:0] <= `DIOC_HZ_MAX)
                            bandLow_ff <= wData_ff[11:0];
                    `DIOC_OFF_BAND_HIGH:
                        if (wData_ff[11:0] != 12'h0 && wData_ff[11:0] <= `DIOC_HZ_MAX)
                            bandHigh_ff <= wData_ff[11:0];
                    `DIOC_OFF_PULSE_OFFSET:
                        if (offsIn >= -`DIOC_OFFSET_LIMIT && offsIn <= `DIOC_OFFSET_LIMIT)
                            pulseOffset_ff <= wData_ff[10:0];
                    `DIOC_OFF_FILTER_TIME:
                        if (wData_ff[10:0] <= `DIOC_FILTER_MAX)
                            filterTime_ff <= wData_ff[10:0];
                    `DIOC_OFF_POLARITY: polarity_ff <= wData_ff[0];
                    `DIOC_OFF_FUNC_LO:
                        if (driveStopped && funcOk(funcIn))
                            inputFunc_ff[23:0] <= funcIn;
                    `DIOC_OFF_FUNC_HI:
                        if (driveStopped && funcOk(funcIn))
                            inputFunc_ff[47:24] <= funcIn;
                    default:
                        polarity_ff <= polarity_ff;
                endcase
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // digital inputs and pulse rate
    // ----------------------------------------
    reg [7:0] selMask;
    reg [7:0] diActive;
    reg fireAny;
    integer i;
    always @*
    begin
        selMask = 8'h0;
        fireAny = 1'b0;
        // selector 1..4 maps inputs one to four
        // the selected input taken whatever its function
        case (pulseSel_ff)
            3'h1: selMask = 8'h01;
            3'h2: selMask = 8'h02;
            3'h3: selMask = 8'h04;
            3'h4: selMask = 8'h08;
            default: selMask = 8'h00;
        endcase
        // polarity: 0 sinking (low active), 1 sourcing (high active)
        diActive = (polarity_ff ? digitalInputPin : ~digitalInputPin) & ~selMask;
        // fire mode code, ignored on the pulse input
        for (i = 0; i < 8; i = i + 1)
            if (diActive[i] && inputFunc_ff[i * 6 +: 6] == `DIOC_FUNC_FIRE)
                fireAny = 1'b1;
    end

    reg pinPrev_ff;
    reg [11:0] edgeCnt_ff;
    reg [31:0] gateCnt_ff;
    reg [31:0] stepCnt_ff;
    reg signed [15:0] filtAcc_ff;
    wire pinNow = |(digitalInputPin & selMask);
    wire pinRise = pinNow && !pinPrev_ff;
    // an edge on the closing cycle of a gate still belongs to that gate
    wire [12:0] edgeTotal = {1'b0, edgeCnt_ff} + {12'h0, pinRise};
    wire gateEnd = gateCnt_ff == GATE_CYCLES - 1;
    wire stepEnd = stepCnt_ff == STEP_CYCLES - 1;
    wire signed [15:0] target = pulsePercent(pulseHz_ff, bandLow_ff, bandHigh_ff,
        pulseOffset_ff, pulseGain_ff);
    wire signed [16:0] filtErr = target - filtAcc_ff;
    wire signed [16:0] filtStep = filtErr / $signed({6'h0, filterTime_ff} + 17'sh1);
    wire signed [16:0] nxt_filt = filtAcc_ff + filtStep;

    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinPrev_ff <= 1'b0;
            edgeCnt_ff <= 12'h0;
            gateCnt_ff <= 32'h0;
            stepCnt_ff <= 32'h0;
            pulseHz_ff <= 12'h0;
            filtAcc_ff <= 16'sh0;
            pulseValue_ff <= 16'h0;
            diState_ff <= 8'h0;
            fireModeReq_ff <= 1'b0;
            aout1Level_ff <= 16'h0;
            aout2Level_ff <= 16'h0;
        end
        else
        begin
            pinPrev_ff <= pinNow;
            // status word bit n is input n+1
            diState_ff <= diActive;
            fireModeReq_ff <= fireAny;
            gateCnt_ff <= gateEnd ? 32'h0 : gateCnt_ff + 32'h1;
            stepCnt_ff <= stepEnd ? 32'h0 : stepCnt_ff + 32'h1;
            // count rising edges over a one second gate
            if (gateEnd)
                edgeCnt_ff <= 12'h0;
            else if (pinRise && edgeCnt_ff != 12'hfff)
                edgeCnt_ff <= edgeCnt_ff + 12'h1;
            // no selector, rate held at zero
            if (pulseSel_ff == 3'h0)
                pulseHz_ff <= 12'h0;
            else if (gateEnd)
                pulseHz_ff <= (edgeTotal > {1'b0, `DIOC_HZ_MAX}) ? `DIOC_HZ_MAX : edgeTotal[11:0];
            // first-order filter, time constant in 10 ms steps
            if (filterTime_ff == 11'h0)
                filtAcc_ff <= target;
            else if (stepEnd)
                filtAcc_ff <= nxt_filt[15:0];
            pulseValue_ff <= filtAcc_ff;
            aout1Level_ff <= aoLevel(aout1Cfg_ff, hostSrcA_ff, hostSrcB_ff, scriptValue,
                torqueValue);
            aout2Level_ff <= aoLevel(aout2Cfg_ff, hostSrcA_ff, hostSrcB_ff, scriptValue,
                torqueValue);
        end
    end

endmodule // dioc_top

`default_nettype wire

// ==== test/dioc_io_asserts.sv ====
// port relations of the conditioning block
`timescale 1ns/1ps
`default_nettype none
module dioc_io_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // levels
    input wire logic [15:0] pulseValue_ff,
    input wire logic [15:0] aout1Level_ff,
    input wire logic [15:0] aout2Level_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------
    // assertions
    // ----------
    AST_AO1_SAT: assert property (aout1Level_ff <= 16'h4e20)
        else $error("aout1 level beyond range");
    AST_AO2_SAT: assert property (aout2Level_ff <= 16'h4e20)
        else $error("aout2 level beyond range");
    AST_PV_CLAMP: assert property (pulseValue_ff != 16'h8000)
        else $error("pulse value not clamped");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> $rose(s_axi_rvalid))
        else $error("read answer late");
    AST_RD_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_WR_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    AST_ERR_ZERO: assert property (
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
endmodule // dioc_io_asserts
`default_nettype wire

// ==== test/dioc_field_model.sv ====
// pulse source standing on one field input
`timescale 1ns/1ps
`default_nettype none
module dioc_field_model #(
    parameter PERIOD = 5
) (
    // clock and control
    input wire logic core_clk,
    input wire logic pulseEn,
    // field pin
    output logic pulsePin
);
    int cnt_ff = 0;
    initial pulsePin = 1'b0;
    always @(posedge core_clk)
    begin
        cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
        pulsePin <= pulseEn && cnt_ff < 2;
    end
endmodule // dioc_field_model
`default_nettype wire

// ==== test/dioc_top_test.sv ====
// self-checking bench of the conditioning block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module dioc_top_test;
    logic core_clk = 1'b0, sys_rst = 1'b1, driveStopped = 1'b1, pulseEn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, pins = 8'h00, p;
    logic [31:0] wd = 32'h0;
    logic [15:0] hA, hB, v, scr = 16'h0, trq = 16'h0;
    logic [33:0] ex;
    logic [33:0] exq[$];
    wire awr, wRdy, bv, arr, rv, fire, pPin;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [15:0] pv, ao1, ao2;
    wire [7:0] dinPin = {pins[7:3], pPin, pins[1:0]};
    int fails = 0, checked = 0, cyc = 0, g;
    logic [7:0] rsA [7] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h38};
    logic [31:0] rsV [7] = '{32'h3e8, 32'h3e8, 32'h3e8, 32'h64, 32'h3e8, 32'h0, 32'h0};
    dioc_top #(.GATE_CYCLES(1000), .STEP_CYCLES(50)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rRdy),
        .driveStopped(driveStopped), .scriptValue(scr), .torqueValue(trq),
        .pulseValue_ff(pv), .fireModeReq_ff(fire), .digitalInputPin(dinPin),
        .aout1Level_ff(ao1), .aout2Level_ff(ao2));
    dioc_field_model i_src (.core_clk(core_clk), .pulseEn(pulseEn), .pulsePin(pPin));
    initial
        forever #4 core_clk = ~core_clk;
    task automatic complete_run();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ---------
    // bus tasks
    // ---------
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] e);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge core_clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        while (!(ad && dd))
        begin
            @(posedge core_clk);
            if (awr === 1'b1 && awv) ad = 1;
            if (wRdy === 1'b1 && wv) dd = 1;
            awv <= !ad;
            wv <= !dd;
        end
        do @(posedge core_clk); while (bv !== 1'b1);
        bRdy <= 1;
        @(posedge core_clk);
        bRdy <= 0;
        `CHK(br, e)
    endtask
    task automatic rd(input [7:0] a, input [33:0] e);
        @(posedge core_clk);
        ara <= a;
        arv <= 1;
        exq.push_back(e);
        do @(posedge core_clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge core_clk); while (rv !== 1'b1);
        rRdy <= 1;
        @(posedge core_clk);
        rRdy <= 0;
    endtask
    function automatic [15:0] aoLevel(input [2:0] ty, input [63:0] x, sc, gn);
        logic [63:0] b, sp;
        sp = (ty == 0 || ty == 3) ? 10000 : (ty == 2 || ty == 5) ? 16000 : 20000;
        b = x * gn * sp / (sc * 1000);
        if (b > sp) b = sp;
        aoLevel = (ty == 2) ? 4000 + b : (ty == 3) ? 10000 - b : (ty > 3) ? 20000 - b : b;
    endfunction
    always @(posedge core_clk)
    begin
        if (rv === 1'b1 && rRdy === 1'b1)
        begin
            ex = exq.pop_front();
            `CHK({rr, rdat}, ex)
        end
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            complete_run();
        end
    end
    // -------------
    // main sequence
    // -------------
    initial
    begin
        void'($urandom(32'h6e64cfab));
        hA = $urandom;
        hB = $urandom;
        repeat (20) @(posedge core_clk);
        sys_rst <= 0;
        scr <= $urandom % 32768;
        trq <= $urandom % 2000;
        for (int i = 0; i < 7; i++)
            rd(rsA[i], {2'h0, rsV[i]});
        $display("reset values done");
        wr(8'h08, {16'h0, hA}, 0);
        wr(8'h0c, {16'h0, hB}, 0);
        for (int t = 0; t < 6; t++)
        begin
            g = (t == 5) ? 9999 : $urandom % 10000;
            wr(8'h00, (t % 4) << 20 | t << 16 | g, 0);
            v = (t % 4 == 0) ? hA : (t % 4 == 1) ? hB : (t % 4 == 2) ? scr : trq;
            rd(8'h40, {2'h0, aoLevel(0, hA, 32767, 1000),
                aoLevel(t[2:0], v, (t % 4 == 3) ? 2000 : 32767, g)});
        end
        `CHK(ao2, aoLevel(0, hA, 32767, 1000))
        wr(8'h00, 32'h000603e8, 0);
        rd(8'h00, 34'h0015270f);
        `CHK(ao1, aoLevel(5, hB, 32767, 9999))
        $display("analog outputs done");
        driveStopped <= 0;
        wr(8'h10, 32'h3, 0);
        rd(8'h10, 34'h0);
        driveStopped <= 1;
        p = $urandom;
        pins <= p;
        wr(8'h10, 32'h3, 0);
        wr(8'h28, 32'h1, 0);
        pulseEn <= 1;
        repeat (2500) @(posedge core_clk);
        rd(8'h38, 34'd200);
        `CHK(pv, 16'h0e38)
        rd(8'h34, {26'h0, p & 8'hfb});
        wr(8'h28, 32'h0, 0);
        rd(8'h34, {26'h0, ~p & 8'hfb});
        wr(8'h20, 32'hfffffe0c, 0);
        wr(8'h14, 32'h7d0, 0);
        repeat (10) @(posedge core_clk);
        `CHK(pv, 16'h9c72)
        // halving steps settle one count short of the new target
        wr(8'h24, 32'h1, 0);
        wr(8'h14, 32'h3e8, 0);
        repeat (1000) @(posedge core_clk);
        `CHK(pv, 16'hce38)
        pulseEn <= 0;
        wr(8'h10, 32'h0, 0);
        repeat (10) @(posedge core_clk);
        rd(8'h38, 34'h0);
        $display("pulse input done");
        wr(8'h18, 32'h0, 0);
        wr(8'h18, 32'hbb9, 0);
        rd(8'h18, 34'h64);
        wr(8'h1c, 32'hbb8, 0);
        rd(8'h1c, 34'hbb8);
        wr(8'h14, 32'h2710, 0);
        rd(8'h14, 34'h3e8);
        wr(8'h20, 32'h0, 0);
        wr(8'h20, 32'h3e9, 0);
        rd(8'h20, 34'h0);
        wr(8'h28, 32'h1, 0);
        pins <= 8'h01;
        wr(8'h2c, 32'h31, 0);
        repeat (3) @(posedge core_clk);
        `CHK(fire, 1'b1)
        wr(8'h2c, 32'h3a, 0);
        rd(8'h2c, 34'h31);
        wr(8'h44, 32'h0, 2'h2);
        rd(8'h44, {2'h2, 32'h0});
        $display("limits and fire done");
        complete_run();
    end
endmodule // dioc_top_test
bind dioc_top dioc_io_asserts i_chk (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .pulseValue_ff(pulseValue_ff), .aout1Level_ff(aout1Level_ff),
    .aout2Level_ff(aout2Level_ff));
`default_nettype wire
